// File: rtl/cis_pkg.sv
// constants, types and the state record of the byte compare unit
// assumes one 100 MHz clock and a memory that answers within the cycle of its read pulse
package cis_pkg;

  // register byte offsets on the bus
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h04;
  localparam logic [7:0] OFS_ACC = 8'h08;
  localparam logic [7:0] OFS_FLAGS = 8'h0C;
  localparam logic [7:0] OFS_COUNT = 8'h10;
  localparam logic [7:0] OFS_POINTER = 8'h14;
  localparam logic [7:0] OFS_INDEX1 = 8'h18;
  localparam logic [7:0] OFS_INDEX2 = 8'h1C;
  localparam logic [7:0] OFS_GEN_DE = 8'h20;
  localparam logic [7:0] OFS_PC = 8'h24;

  // control and status fields
  localparam int CTRL_WIDE = 0;
  localparam int CTRL_START = 1;
  localparam int CTRL_MBASE_LO = 8;
  localparam int STAT_BUSY = 0;
  localparam int STAT_ILLEGAL = 1;

  // flag bit positions
  localparam int FLG_S = 7;
  localparam int FLG_Z = 6;
  localparam int FLG_H = 4;
  localparam int FLG_PV = 2;
  localparam int FLG_N = 1;
  localparam int FLG_C = 0;

  // opcodes
  localparam logic [7:0] OPC_PFX_S = 8'h52;
  localparam logic [7:0] OPC_PFX_L = 8'h49;
  localparam logic [7:0] OPC_IMM = 8'hFE;
  localparam logic [7:0] OPC_IDX1 = 8'hDD;
  localparam logic [7:0] OPC_IDX2 = 8'hFD;
  localparam logic [7:0] OPC_EXT = 8'hED;
  localparam logic [7:0] OPC_IDX_HI = 8'hBC;
  localparam logic [7:0] OPC_IDX_LO = 8'hBD;
  localparam logic [7:0] OPC_IDX_MEM = 8'hBE;
  localparam logic [4:0] OPC_REG_GRP = 5'h17;
  localparam logic [2:0] OPC_REG_MEM = 3'h6;
  localparam logic [7:0] OPC_CPD = 8'hA9;
  localparam logic [7:0] OPC_COMPARE_DECREMENT_REPEAT = 8'hB9;
  localparam logic [7:0] OPC_CPI = 8'hA1;
  localparam logic [7:0] OPC_CPIR = 8'hB1;

  // values after reset, and the one and two steps for pair arithmetic
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [23:0] RST_WORD = 24'h00_0000;
  localparam logic [31:0] RST_RDATA = 32'h0000_0000;
  localparam logic [23:0] ONE24 = 24'h00_0001;
  localparam logic [23:0] TWO24 = 24'h00_0002;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_OP = 3'b001,
    ST_OP2 = 3'b010,
    ST_DISP = 3'b011,
    ST_OPND = 3'b100,
    ST_REPEND = 3'b101
  } cis_state_t;

  typedef struct packed {
    cis_state_t state;
    logic [7:0] acc;
    logic [7:0] flags;
    logic [7:0] reg_d;
    logic [7:0] reg_e;
    logic [7:0] mbase;
    logic [23:0] ptr;
    logic [23:0] cnt;
    logic [23:0] ix;
    logic [23:0] iy;
    logic [23:0] pc;
    logic wide_mode;
    logic wide_eff;
    logic pfx;
    logic ext;
    logic use_iy;
    logic [7:0] op;
    logic illegal;
    logic dp_wr;
    logic [7:0] dp_addr;
    logic [31:0] hrdata;
    logic hready;
    logic resp;
    logic busy;
    logic mem_rd;
    logic [23:0] mem_addr;
  } cis_state_rec_t;

endpackage

// File: rtl/cis_flag_alu.sv
// subtract-for-flags datapath of the byte compare unit
// purely combinational; the caller registers whatever it keeps
`timescale 1ns/10ps
module cis_flag_alu (
  // operands
  input wire logic [7:0] acc,
  input wire logic [7:0] opnd,
  // results
  output logic sign,
  output logic zero,
  output logic half,
  output logic ovf,
  output logic borrow
);

  logic [8:0] diff;

  always_comb begin
    diff = {1'b0, acc} - {1'b0, opnd};
    sign = diff[7];
    zero = (acc == opnd);
    half = (acc[3:0] < opnd[3:0]);
    ovf = (acc[7] != opnd[7]) && (diff[7] != acc[7]);
    borrow = diff[8];
  end

endmodule

// File: rtl/cis_compare_unit.sv
// byte compare execution unit with AHB-Lite register slave and memory read port
// assumes a memory that drives mem_rdata within the cycle in which mem_rd stands
`timescale 1ns/10ps
module cis_compare_unit
  import cis_pkg::*;
(
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // operand and instruction memory
  output logic mem_rd,
  output logic [23:0] mem_addr,
  input wire logic [7:0] mem_rdata,
  // status
  output logic busy
);

  cis_state_rec_t q, c;
  logic [7:0] opnd;
  logic f_s, f_z, f_h, f_v, f_c;

  ////////////////////////////////////////////////////////////////////////////
  // helpers

  // selects a register operand from the low opcode bits
  function automatic logic [7:0] reg_pick(input cis_state_rec_t s, input logic [2:0] sel);
    case (sel)
      3'h0: reg_pick = s.cnt[15:8];
      3'h1: reg_pick = s.cnt[7:0];
      3'h2: reg_pick = s.reg_d;
      3'h3: reg_pick = s.reg_e;
      3'h4: reg_pick = s.ptr[15:8];
      3'h5: reg_pick = s.ptr[7:0];
      3'h7: reg_pick = s.acc;
      default: reg_pick = RST_BYTE;
    endcase
  endfunction
  // memory address in the effective width; short form sits in the mbase page
  function automatic logic [23:0] eff_addr(input logic [23:0] v, input logic wide,
                                           input logic [7:0] page);
    eff_addr = wide ? v : {page, v[15:0]};
  endfunction
  // pair update that leaves the top byte alone in 16-bit mode
  function automatic logic [23:0] pair_step(input logic [23:0] old, input logic [23:0] nv,
                                            input logic wide);
    pair_step = wide ? nv : {old[23:16], nv[15:0]};
  endfunction
  function automatic logic pair_nz(input logic [23:0] v, input logic wide);
    pair_nz = wide ? (v != RST_WORD) : (v[15:0] != 16'h0000);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // datapath

  assign opnd = (q.state == ST_OPND) ? mem_rdata : reg_pick(q, mem_rdata[2:0]);

  cis_flag_alu u_alu (
    .acc(q.acc),
    .opnd(q.state == ST_OP2 ? (mem_rdata[0] ? (q.use_iy ? q.iy[7:0] : q.ix[7:0])
                                            : (q.use_iy ? q.iy[15:8] : q.ix[15:8]))
                            : opnd),
    .sign(f_s),
    .zero(f_z),
    .half(f_h),
    .ovf(f_v),
    .borrow(f_c)
  );

  ////////////////////////////////////////////////////////////////////////////
  // next state

  always_comb begin
    logic [23:0] cnt_new;
    logic [23:0] ptr_new;
    logic [23:0] idx;
    logic [7:0] single_flags;
    logic blk_more;
    cnt_new = RST_WORD;
    ptr_new = RST_WORD;
    idx = RST_WORD;
    single_flags = RST_BYTE;
    blk_more = 1'b0;
    c = q;
    c.mem_rd = 1'b0;
    c.hready = 1'b1;
    c.dp_wr = 1'b0;
    // full flag set of a single compare; acc is assigned here only by a bus write to OFS_ACC while idle
    single_flags[FLG_S] = f_s;
    single_flags[FLG_Z] = f_z;
    single_flags[FLG_H] = f_h;
    single_flags[FLG_PV] = f_v;
    single_flags[FLG_N] = 1'b1;
    single_flags[FLG_C] = f_c;

    case (q.state)
      ST_IDLE: ;
      ST_OP: begin
        if (!q.pfx && (mem_rdata == OPC_PFX_S || mem_rdata == OPC_PFX_L)) begin
          c.pfx = 1'b1;
          c.wide_eff = (mem_rdata == OPC_PFX_L);
          c.mem_rd = 1'b1;
          c.mem_addr = q.pc;
          c.pc = q.pc + ONE24;
        end else if (mem_rdata[7:3] == OPC_REG_GRP && mem_rdata[2:0] == OPC_REG_MEM) begin
          c.mem_rd = 1'b1;
          c.mem_addr = eff_addr(q.ptr, q.wide_eff, q.mbase);
          c.ext = 1'b0;
          c.state = ST_OPND;
        end else if (mem_rdata[7:3] == OPC_REG_GRP) begin
          c.flags = single_flags;
          c.state = ST_IDLE;
        end else if (mem_rdata == OPC_IMM) begin
          c.mem_rd = 1'b1;
          c.mem_addr = q.pc;
          c.pc = q.pc + ONE24;
          c.ext = 1'b0;
          c.state = ST_OPND;
        end else if (mem_rdata == OPC_IDX1 || mem_rdata == OPC_IDX2 ||
                     mem_rdata == OPC_EXT) begin
          c.use_iy = (mem_rdata == OPC_IDX2);
          c.ext = (mem_rdata == OPC_EXT);
          c.mem_rd = 1'b1;
          c.mem_addr = q.pc;
          c.pc = q.pc + ONE24;
          c.state = ST_OP2;
        end else begin
          c.illegal = 1'b1;
          c.state = ST_IDLE;
        end
      end
      ST_OP2: begin
        c.op = mem_rdata;
        if (q.ext && (mem_rdata == OPC_CPD || mem_rdata == OPC_COMPARE_DECREMENT_REPEAT ||
                      mem_rdata == OPC_CPI || mem_rdata == OPC_CPIR)) begin
          c.mem_rd = 1'b1;
          c.mem_addr = eff_addr(q.ptr, q.wide_eff, q.mbase);
          c.state = ST_OPND;
        end else if (!q.ext && (mem_rdata == OPC_IDX_HI || mem_rdata == OPC_IDX_LO)) begin
          c.flags = single_flags;
          c.state = ST_IDLE;
        end else if (!q.ext && mem_rdata == OPC_IDX_MEM) begin
          c.mem_rd = 1'b1;
          c.mem_addr = q.pc;
          c.pc = q.pc + ONE24;
          c.state = ST_DISP;
        end else begin
          c.illegal = 1'b1;
          c.state = ST_IDLE;
        end
      end
      ST_DISP: begin
        idx = q.use_iy ? q.iy : q.ix;
        c.mem_rd = 1'b1;
        c.mem_addr = eff_addr(idx + {{16{mem_rdata[7]}}, mem_rdata}, q.wide_eff,
                              q.mbase);
        c.state = ST_OPND;
      end
      ST_OPND: begin
        if (q.ext) begin
          cnt_new = pair_step(q.cnt, q.cnt - ONE24, q.wide_eff);
          ptr_new = q.op[3] ? q.ptr - ONE24 : q.ptr + ONE24;
          c.cnt = cnt_new;
          c.ptr = pair_step(q.ptr, ptr_new, q.wide_eff);
          c.flags[FLG_S] = f_s;
          c.flags[FLG_Z] = f_z;
          c.flags[FLG_H] = f_h;
          c.flags[FLG_N] = 1'b1;
          c.flags[FLG_PV] = pair_nz(cnt_new, q.wide_eff);
          blk_more = q.op[4] && !f_z && pair_nz(cnt_new, q.wide_eff);
          if (blk_more) begin
            // rewind over ED and the second opcode; a prefix is kept, not refetched
            c.mem_rd = 1'b1;
            c.mem_addr = q.pc - TWO24;
            c.pc = q.pc - ONE24;
            c.state = ST_OP;
          end else begin
            c.state = q.op[4] ? ST_REPEND : ST_IDLE;
          end
        end else begin
          c.flags = single_flags;
          c.state = ST_IDLE;
        end
      end
      ST_REPEND: begin
        c.state = ST_IDLE;
      end
      default: begin
        c.state = ST_IDLE;
      end
    endcase

    // register writes take effect only while idle so software never races the engine
    if (q.dp_wr && q.state == ST_IDLE) begin
      case (q.dp_addr)
        OFS_CTRL: begin
          c.wide_mode = hwdata[CTRL_WIDE];
          c.mbase = hwdata[CTRL_MBASE_LO +: 8];
          if (hwdata[CTRL_START]) begin
            c.state = ST_OP;
            c.mem_rd = 1'b1;
            c.mem_addr = q.pc;
            c.pc = q.pc + ONE24;
            c.pfx = 1'b0;
            c.wide_eff = hwdata[CTRL_WIDE];
            c.illegal = 1'b0;
          end
        end
        OFS_ACC: c.acc = hwdata[7:0];
        OFS_FLAGS: c.flags = hwdata[7:0];
        OFS_COUNT: c.cnt = hwdata[23:0];
        OFS_POINTER: c.ptr = hwdata[23:0];
        OFS_INDEX1: c.ix = hwdata[23:0];
        OFS_INDEX2: c.iy = hwdata[23:0];
        OFS_GEN_DE: begin
          c.reg_d = hwdata[15:8];
          c.reg_e = hwdata[7:0];
        end
        OFS_PC: c.pc = hwdata[23:0];
        default: ;
      endcase
    end

    c.busy = (c.state != ST_IDLE);
    // address phase: capture writes, answer reads in the following data phase
    if (hsel && htrans[1] && hready) begin
      c.dp_wr = hwrite;
      c.dp_addr = haddr[7:0];
      case (haddr[7:0])
        OFS_CTRL: c.hrdata = {16'h0000, q.mbase, 7'h00, q.wide_mode};
        OFS_STATUS: c.hrdata = {16'h0000, q.flags, 6'h00, q.illegal,
                                q.state != ST_IDLE};
        OFS_ACC: c.hrdata = {24'h00_0000, q.acc};
        OFS_FLAGS: c.hrdata = {24'h00_0000, q.flags};
        OFS_COUNT: c.hrdata = {8'h00, q.cnt};
        OFS_POINTER: c.hrdata = {8'h00, q.ptr};
        OFS_INDEX1: c.hrdata = {8'h00, q.ix};
        OFS_INDEX2: c.hrdata = {8'h00, q.iy};
        OFS_GEN_DE: c.hrdata = {16'h0000, q.reg_d, q.reg_e};
        OFS_PC: c.hrdata = {8'h00, q.pc};
        default: c.hrdata = RST_RDATA;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // registers

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      q <= '0;
      q.hready <= 1'b1;
    end else begin
      q <= c;
    end
  end

  assign hreadyout = q.hready;
  assign hresp = q.resp;
  assign hrdata = q.hrdata;
  assign mem_rd = q.mem_rd;
  assign mem_addr = q.mem_addr;
  assign busy = q.busy;

  ////////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  sequence s_refetch;
    q.state == ST_OP ##1 q.state == ST_OP2 ##1 q.state == ST_OPND;
  endsequence
  sequence s_finish;
    q.state == ST_REPEND ##1 q.state == ST_IDLE;
  endsequence

  a_acc_held: assert property ((q.state != ST_IDLE) |=> q.acc == $past(q.acc))
    else $error("accumulator changed during a compare");
  a_sub_flag: assert property ((q.state == ST_OPND) |=> q.flags[FLG_N])
    else $error("subtract flag not set after compare");
  a_zero_equal: assert property ((q.state == ST_OPND) |=>
                                 q.flags[FLG_Z] == ($past(q.acc) == $past(mem_rdata)))
    else $error("zero flag does not match equality");
  a_half_borrow: assert property ((q.state == ST_OPND && !q.ext) |=>
                                  q.flags[FLG_H] == ($past(q.acc[3:0]) <
                                                     $past(mem_rdata[3:0])))
    else $error("half flag wrong");
  a_carry_kept: assert property ((q.state == ST_OPND && q.ext) |=>
                                 $stable(q.flags[FLG_C]))
    else $error("block compare changed carry");
  a_borrow_carry: assert property ((q.state == ST_OPND && !q.ext) |=>
                                   q.flags[FLG_C] == ($past(q.acc) < $past(mem_rdata)))
    else $error("carry flag wrong");
  a_count_dec: assert property ((q.state == ST_OPND && q.ext) |=>
                                q.cnt[15:0] == $past(q.cnt[15:0]) - 16'h0001)
    else $error("count_pair not decremented");
  a_ptr_inc: assert property ((q.state == ST_OPND && q.ext && !q.op[3]) |=>
                              q.ptr[15:0] == $past(q.ptr[15:0]) + 16'h0001)
    else $error("pointer_pair not incremented");
  a_rep_loop: assert property ((q.state == ST_OPND && q.ext && q.op[4] && !f_z &&
                                pair_nz(pair_step(q.cnt, q.cnt - ONE24, q.wide_eff),
                                        q.wide_eff)) |=> s_refetch)
    else $error("repeat step not three cycles");
  a_rep_end: assert property ((q.state == ST_OPND && q.ext && q.op[4] && f_z) |=>
                              s_finish)
    else $error("repeat did not stop on match");
  a_reg_cycle: assert property ((q.state == ST_OP && mem_rdata[7:3] == OPC_REG_GRP &&
                                 mem_rdata[2:0] != OPC_REG_MEM) |=>
                                q.state == ST_IDLE)
    else $error("register compare not one cycle");

endmodule

// File: bench/cis_mem_model.sv
// memory model holding instruction bytes and operands for the compare unit
// assumes the unit samples mem_rdata at the rising edge that ends the cycle of mem_rd
`timescale 1ns/10ps
module cis_mem_model (
  // clock
  input wire logic hclk,
  // read port
  input wire logic mem_rd,
  input wire logic [23:0] mem_addr,
  output logic [7:0] mem_rdata
);
  logic [7:0] mem [logic [23:0]];
  initial mem_rdata = 8'h00;
  ////////////////////////////////////////////////////////////////////////////////
  // answers on the falling edge, so the byte stands before the unit samples it;
  // between answers the byte toggles, so a sample one cycle late sees the inverted byte
  always @(negedge hclk) begin
    if (mem_rd) begin
      mem_rdata <= mem.exists(mem_addr) ? mem[mem_addr] : 8'h00;
    end else begin
      mem_rdata <= ~mem_rdata;
    end
  end
endmodule

// File: bench/cis_compare_unit_tb.sv
// self-checking bench for the byte compare unit: bus tasks, instruction runs, flag checks
// assumes the unit is the only AHB-Lite slave and the memory model feeds its read port
`timescale 1ns/10ps
module cis_compare_unit_tb
  import cis_pkg::*;
;
  logic hclk, hresetn, hsel, hwrite, wide, hreadyout, hresp, mem_rd, busy;
  logic [31:0] haddr, hwdata, hrdata, v;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [23:0] mem_addr;
  logic [7:0] mem_rdata, a, b, mb;
  logic [2:0] j;
  int err_count, n_tests;
  logic [7:0] ih [4] = '{8'h20, 8'h80, 8'h30, 8'h01};
  logic [7:0] rg [8] = '{8'hC3, 8'h80, 8'h7F, 8'h01, 8'h0F, 8'h10, 8'h00, 8'h00};

  cis_compare_unit dut_u (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .mem_rd(mem_rd),
    .mem_addr(mem_addr), .mem_rdata(mem_rdata), .busy(busy)
  );
  cis_mem_model mem_u (.hclk(hclk), .mem_rd(mem_rd), .mem_addr(mem_addr), .mem_rdata(mem_rdata));

  initial begin
    hclk = 1'b0;
    forever #5 hclk = ~hclk;
  end
  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      err_count++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // entered just after a rising edge; returns at the edge that carries read data
  task automatic bus(input logic [7:0] ad, input logic w, input logic [31:0] wd,
                     output logic [31:0] d);
    hsel <= 1'b1;
    haddr <= {24'h00_0000, ad};
    hwrite <= w;
    htrans <= 2'b10;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'b00;
    hwdata <= wd;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    d = hrdata;
    chk("hresp", {31'h0, hresp}, 32'h0000_0000);
  endtask

  task automatic wr(input logic [7:0] ad, input logic [31:0] wd);
    logic [31:0] x;
    bus(ad, 1'b1, wd, x);
  endtask

  task automatic rd(input logic [7:0] ad, output logic [31:0] d);
    bus(ad, 1'b0, 32'h0000_0000, d);
  endtask

  function automatic logic [7:0] fexp(input logic [7:0] x, y, f, input logic blk, pv);
    logic [8:0] d;
    d = {1'b0, x} - {1'b0, y};
    fexp = {d[7], d[7:0] == 8'h00, 1'b0, x[3:0] < y[3:0], 1'b0,
            blk ? pv : (x[7] != y[7]) && (d[7] != x[7]), 1'b1, blk ? f[0] : d[8]};
  endfunction

  // bits 5 and 3 are left out: their value after a compare is not defined
  task automatic post(input logic [7:0] x, y, f, input logic blk, pv);
    logic [31:0] r;
    rd(OFS_FLAGS, r);
    chk("flags", r & 32'h0000_00D7, {24'h00_0000, fexp(x, y, f, blk, pv)});
    rd(OFS_ACC, r);
    chk("acc", r, {24'h00_0000, x});
  endtask

  task automatic pairs(input logic [23:0] c, p);
    logic [31:0] r;
    rd(OFS_COUNT, r);
    chk("count", r, {8'h00, c});
    rd(OFS_POINTER, r);
    chk("pointer", r, {8'h00, p});
  endtask

  task automatic su(input logic [7:0] x, f, input logic [23:0] c, p);
    wr(OFS_ACC, {24'h00_0000, x});
    wr(OFS_FLAGS, {24'h00_0000, f});
    wr(OFS_COUNT, {8'h00, c});
    wr(OFS_POINTER, {8'h00, p});
  endtask

  // code holds the instruction bytes, first byte in the low eight bits
  task automatic exec(input logic [31:0] code, input int nb, input int ncyc);
    int n;
    for (int i = 0; i < nb; i++) begin
      mem_u.mem[24'h00_0100 + 24'(i)] = code[8*i +: 8];
    end
    wr(OFS_CTRL, {16'h0000, mb, 7'h00, wide});
    wr(OFS_PC, 32'h0000_0100);
    wr(OFS_CTRL, {16'h0000, mb, 6'h00, 1'b1, wide});
    n = 0;
    do begin
      @(posedge hclk);
      n++;
    end while (busy !== 1'b0 && n < 400);
    chk("cycles", 32'(n - 1), 32'(ncyc));
  endtask

  task automatic conclude();
    $display("checks %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (20000) @(posedge hclk);
    err_count++;
    conclude();
  end

  initial begin
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0000_0000;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0000_0000;
    wide = 1'b0;
    mb = 8'h00;
    err_count = 0;
    n_tests = 0;
    repeat (16) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    for (int o = 0; o <= 64; o += 4) begin
      rd(8'(o), v);
      chk("reset", v, RST_RDATA);
    end
    wr(OFS_INDEX1, 32'h0000_2080);
    wr(OFS_INDEX2, 32'h0000_3001);
    wr(OFS_GEN_DE, 32'h0000_7F01);
    mem_u.mem[24'h00_0F10] = 8'h90;
    mem_u.mem[24'h00_0F0F] = 8'h91;
    mem_u.mem[24'h00_0F0E] = 8'h92;
    mem_u.mem[24'h00_2070] = 8'h21;
    mem_u.mem[24'h00_3006] = 8'h20;
    // 80h against positive operands overflows; 3Ch against C3h borrows without it
    for (int k = 0; k < 16; k++) begin
      a = k[3] ? 8'h3C : 8'h80;
      j = k[2:0];
      b = (j == 3'h7) ? a : rg[j];
      if (j != 3'h6) begin
        su(a, 8'h00, 24'h00_C380, 24'h00_0F10);
        exec({24'h00_0000, OPC_REG_GRP, j}, 1, 1);
        post(a, b, 8'h00, 1'b0, 1'b0);
      end
    end
    for (int k = 0; k < 3; k++) begin
      su(8'h10, 8'h00, 24'h00_0005, 24'h00_0F10);
      exec(k == 0 ? 32'h0000_00BE : (k == 1 ? 32'h0000_BE52 : 32'h0000_BE49),
           k ? 2 : 1, k ? 3 : 2);
      post(8'h10, 8'h90, 8'h00, 1'b0, 1'b0);
    end
    for (int k = 0; k < 4; k++) begin
      su(8'h20, 8'h00, 24'h00_0005, 24'h00_0F10);
      exec({16'h0000, k[0] ? OPC_IDX_LO : OPC_IDX_HI, k[1] ? OPC_IDX2 : OPC_IDX1}, 2, 2);
      post(8'h20, ih[k], 8'h00, 1'b0, 1'b0);
    end
    exec(32'h00F0_BEDD, 3, 4);
    post(8'h20, 8'h21, 8'h00, 1'b0, 1'b0);
    exec(32'h0005_BEFD, 3, 4);
    post(8'h20, 8'h20, 8'h00, 1'b0, 1'b0);
    su(8'h00, 8'h00, 24'h00_0005, 24'h00_0F10);
    exec(32'h0000_01FE, 2, 2);
    post(8'h00, 8'h01, 8'h00, 1'b0, 1'b0);
    su(8'h10, 8'h01, 24'h00_0001, 24'h00_0F10);
    exec(32'h0000_A9ED, 2, 3);
    post(8'h10, 8'h90, 8'h01, 1'b1, 1'b0);
    pairs(24'h00_0000, 24'h00_0F0F);
    su(8'h90, 8'h00, 24'h00_0002, 24'h00_0F10);
    exec(32'h00A1_ED52, 3, 4);
    post(8'h90, 8'h90, 8'h00, 1'b1, 1'b1);
    pairs(24'h00_0001, 24'h00_0F11);
    // repeat runs out the count, then a second one stops early on a match
    su(8'h10, 8'h01, 24'h00_0003, 24'h00_0F10);
    exec(32'h0000_B9ED, 2, 10);
    post(8'h10, 8'h92, 8'h01, 1'b1, 1'b0);
    pairs(24'h00_0000, 24'h00_0F0D);
    su(8'h91, 8'h00, 24'h00_0005, 24'h00_0F10);
    exec(32'h00B9_ED49, 3, 8);
    post(8'h91, 8'h91, 8'h00, 1'b1, 1'b1);
    pairs(24'h00_0003, 24'h00_0F0E);
    // only the wide mode treats the upper count byte as live
    for (int k = 1; k >= 0; k--) begin
      wide = k[0];
      su(8'h10, 8'h00, 24'h01_0001, 24'h00_0F10);
      exec(32'h0000_A9ED, 2, 3);
      post(8'h10, 8'h90, 8'h00, 1'b1, wide);
      pairs(24'h01_0000, 24'h00_0F0F);
    end
    // increment repeat walks up to a match on the third byte
    su(8'h90, 8'h01, 24'h00_0004, 24'h00_0F0E);
    exec(32'h0000_B1ED, 2, 10);
    post(8'h90, 8'h90, 8'h01, 1'b1, 1'b1);
    pairs(24'h00_0001, 24'h00_0F11);
    // in 16-bit mode the operand address takes its top byte from the page field
    mb = 8'h01;
    mem_u.mem[24'h01_0F10] = 8'h55;
    su(8'h55, 8'h00, 24'h00_0005, 24'h00_0F10);
    exec(32'h0000_00BE, 1, 2);
    post(8'h55, 8'h55, 8'h00, 1'b0, 1'b0);
    mb = 8'h00;
    // an unknown opcode stops at once and leaves the flags alone
    su(8'h00, 8'hA5, 24'h00_0005, 24'h00_0F10);
    exec(32'h0000_00FF, 1, 1);
    rd(OFS_STATUS, v);
    chk("status", v, 32'h0000_A502);
    conclude();
  end
endmodule
